// file: logic/ictm_map.vh
// Opcode classes, result row layout and figures for the cycle timing model
`ifndef ICTM_MAP_VH
`define ICTM_MAP_VH

// Operation classes presented on req_op
`define ICTM_OP_QUICK_CONSTANT_LOAD 6'h00
`define ICTM_OP_QUICK_ADD_REG 6'h01
`define ICTM_OP_QUICK_ADD_MEM 6'h02
`define ICTM_OP_IMM_REG 6'h03
`define ICTM_OP_IMM_MEM 6'h04
`define ICTM_OP_DECIMAL_ADD_EXTEND_REG 6'h05
`define ICTM_OP_DECIMAL_ADD_EXTEND_MEM 6'h06
`define ICTM_OP_EXTEND_ADD_REG 6'h07
`define ICTM_OP_EXTEND_ADD_MEM 6'h08
`define ICTM_OP_MEMORY_COMPARE_POSTINC 6'h09
`define ICTM_OP_CLEAR_REG 6'h0a
`define ICTM_OP_CLEAR_MEM 6'h0b
`define ICTM_OP_NEGATE_REG 6'h0c
`define ICTM_OP_NEGATE_MEM 6'h0d
`define ICTM_OP_SIGN_EXTEND_REG 6'h0e
`define ICTM_OP_DECIMAL_NEGATE_REG 6'h0f
`define ICTM_OP_DECIMAL_NEGATE_MEM 6'h10
`define ICTM_OP_SET_COND_REG 6'h11
`define ICTM_OP_SET_COND_MEM 6'h12
`define ICTM_OP_TEST_AND_SET_REG 6'h13
`define ICTM_OP_TEST_AND_SET_MEM 6'h14
`define ICTM_OP_TEST_MEM 6'h15
`define ICTM_OP_LOGICAL_SHIFT_REGCNT 6'h16
`define ICTM_OP_LOGICAL_SHIFT_IMM 6'h17
`define ICTM_OP_LOGICAL_SHIFT_MEM 6'h18
`define ICTM_OP_ROTATE_THROUGH_EXTEND_REGCNT 6'h19
`define ICTM_OP_ROTATE_THROUGH_EXTEND_IMM 6'h1a
`define ICTM_OP_BIT_CHANGE_IMM_REG 6'h1b
`define ICTM_OP_BIT_CHANGE_REG_REG 6'h1c
`define ICTM_OP_BIT_CHANGE_IMM_MEM 6'h1d
`define ICTM_OP_BIT_CHANGE_REG_MEM 6'h1e
`define ICTM_OP_BIT_TEST_IMM_REG 6'h1f
`define ICTM_OP_BIT_TEST_REG_REG 6'h20
`define ICTM_OP_BIT_TEST_IMM_MEM 6'h21
`define ICTM_OP_BIT_TEST_REG_MEM 6'h22
`define ICTM_OP_BRANCH_TAKEN 6'h23
`define ICTM_OP_BRANCH_BYTE_NOT_TAKEN 6'h24
`define ICTM_OP_BRANCH_WORD_NOT_TAKEN 6'h25
`define ICTM_OP_BRANCH_LONG_NOT_TAKEN 6'h26
`define ICTM_OP_DECREMENT_AND_BRANCH_TRUE 6'h27
`define ICTM_OP_DECREMENT_AND_BRANCH_EXPIRED 6'h28
`define ICTM_OP_DECREMENT_AND_BRANCH_TAKEN 6'h29
`define ICTM_OP_LOOP_DECREMENT_TRUE 6'h2a
`define ICTM_OP_LOOP_DECREMENT_EXPIRED 6'h2b
`define ICTM_OP_LOOP_DECREMENT_TAKEN 6'h2c

// Shift formula selectors
`define ICTM_SHF_NONE 2'h0
`define ICTM_SHF_REGCNT 2'h1
`define ICTM_SHF_ROTX_REG 2'h2
`define ICTM_SHF_ROTX_IMM 2'h3

// Row layout: head, tail, total, reads, prefetches, writes, flags
`define ICTM_ROW_W 41
`define ICTM_ROW_HEAD 40:33
`define ICTM_ROW_TAIL 32:25
`define ICTM_ROW_TOTAL 24:17
`define ICTM_ROW_READS 16:13
`define ICTM_ROW_PREF 12:9
`define ICTM_ROW_WRITES 8:5
`define ICTM_ROW_XLONG 4
`define ICTM_ROW_ADD_EA 3
`define ICTM_ROW_ADD_IMM 2
`define ICTM_ROW_SHF 1:0

// Figures of the timing model
`define ICTM_LONG_EXTRA 10'h002
`define ICTM_SHIFT_FLOOR 7'h06
`define ICTM_ROTX_IMM_MAX 6'h08

`endif

// file: logic/ictm_shift_clocks.v
// Count-dependent head and total clocks for register and immediate count shifts
`timescale 1ns/1ps
`default_nettype none
`include "ictm_map.vh"

module ictm_shift_clocks
(
	// Selector and count
	input wire [1:0] mode,
	input wire [5:0] count,
	// Result
	output reg [6:0] clocks
);

	reg [6:0] quarter;
	reg [6:0] rem4;
	reg [6:0] sum;
	reg [6:0] n;
	reg [6:0] raw;

	always @*
	begin
		quarter = {3'h0, count[5:2]};
		rem4 = {5'h00, count[1:0]};
		sum = quarter + rem4;
		n = {1'h0, count};
		raw = 7'h00;
		case (mode)
			`ICTM_SHF_REGCNT:
				raw = 7'h03 + sum + {6'h00, ~sum[0]};
			`ICTM_SHF_ROTX_REG:
				raw = 7'h03 + n + {6'h00, ~n[0]};
			`ICTM_SHF_ROTX_IMM:
			begin
				// Counts above eight cannot be encoded; clamp defensively
				if (count > `ICTM_ROTX_IMM_MAX)
					n = {1'h0, `ICTM_ROTX_IMM_MAX};
				raw = 7'h02 + n + {6'h00, n[0]};
			end
			default:
				raw = 7'h00;
		endcase
		clocks = (raw < `ICTM_SHIFT_FLOOR) ? `ICTM_SHIFT_FLOOR : raw;
	end

endmodule

`default_nettype wire

// file: logic/ictm_timing.v
// Instruction cycle timing model: per-instruction head, tail, total and bus mix
// What this block does
// - Long memory operands need two bus cycles; quick add, immediate, clear and negate on memory add two clocks to tail and total.
// - Listed counts hold when the external data bus runs 16 bits wide at two-clock accesses.
// - Immediate forms add immediate fetch time to effective address and operation time.
// - Shift and rotate time ignores count except register-count forms and immediate rotate through extend.
// - Register-count shift or rotate: max(3+n/4+n%4+((n/4+n%4+1)%2), 6).
// - Register-count rotate through extend, n up to 63: max(3+n+((n+1)%2), 6).
// - Immediate rotate through extend, n up to 8: max(2+n+(n%2), 6).
// - Quick constant load: 2 clocks, zero head and tail, one prefetch.
// - Quick add to memory: 5 clocks, tail 3, one prefetch, write per bus cycle.
// - Decimal add between predecremented operands: 12 clocks, head 2, tail 2.
// - Postincrement memory compare: 8 clocks, head 1, two reads, one prefetch.
// - Test-and-set on memory: 10 clocks, head 1, one prefetch, one write.
// - Taken conditional branch: 8 clocks, head 2, tail -2, two prefetches.
// - Long not-taken branch: 6 clocks, three prefetches and one write.
// - Decrement-and-branch, false and not expired: 10 clocks, head 6, tail -2.
// - Bit test on a register with register-selected bit: 4 clocks, head 2, one prefetch.
`timescale 1ns/1ps
`default_nettype none
`include "ictm_map.vh"

module ictm_timing
#(
	parameter STREAM_W = 16
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Instruction issue
	input wire req_valid,
	input wire [5:0] req_op,
	input wire req_long,
	input wire [5:0] req_count,
	input wire [7:0] req_ea_clocks,
	input wire [7:0] req_imm_clocks,
	// Bus configuration
	input wire bus_16bit,
	input wire [1:0] bus_wait_clocks,
	// Timing result
	output reg rsp_valid,
	output reg rsp_illegal,
	output reg rsp_nominal,
	output reg [7:0] rsp_head,
	output reg [7:0] rsp_tail,
	output reg [9:0] rsp_total,
	output reg [3:0] rsp_reads,
	output reg [3:0] rsp_prefetch,
	output reg [3:0] rsp_writes,
	// Execution tracking
	output reg busy,
	output reg done,
	output reg [7:0] overlap,
	output reg [STREAM_W-1:0] stream_clocks
);

	// Decoded table row and the figures derived from it
	reg [`ICTM_ROW_W-1:0] row;
	reg known;
	wire [6:0] shift_clocks;
	reg [9:0] next_total;
	reg [7:0] next_head;
	reg [7:0] next_tail;
	reg [3:0] next_reads;
	reg [3:0] next_writes;
	reg [3:0] accesses;
	reg [9:0] wait_extra;
	reg [7:0] next_overlap;
	reg [9:0] long_tail;

	// State carried from one instruction to the next
	reg [7:0] prev_tail;
	reg [9:0] remaining;

	// A request while busy is dropped without notice; the issuer waits for done
	wire take;

	assign take = req_valid && !busy;

	// Count-dependent clocks for the register and immediate count shifts
	ictm_shift_clocks u_shift
	(
		.mode(row[`ICTM_ROW_SHF]),
		.count(req_count),
		.clocks(shift_clocks)
	);

	// Base figures per class; flags say what the caller's extras add
	always @*
	begin
		known = 1'b1;
		row = {`ICTM_ROW_W{1'b0}};
		case (req_op)
			// Quick and immediate arithmetic
			`ICTM_OP_QUICK_CONSTANT_LOAD:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_QUICK_ADD_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_QUICK_ADD_MEM:
				row = {8'h00, 8'h03, 8'h05, 4'h0, 4'h1, 4'h1, 5'h18};
			`ICTM_OP_IMM_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h04};
			`ICTM_OP_IMM_MEM:
				row = {8'h00, 8'h03, 8'h05, 4'h0, 4'h1, 4'h1, 5'h1c};
			// Decimal and extended arithmetic
			`ICTM_OP_DECIMAL_ADD_EXTEND_REG:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_DECIMAL_ADD_EXTEND_MEM:
				row = {8'h02, 8'h02, 8'h0c, 4'h2, 4'h1, 4'h1, 5'h00};
			`ICTM_OP_EXTEND_ADD_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_EXTEND_ADD_MEM:
				row = {8'h02, 8'h02, 8'h0a, 4'h2, 4'h1, 4'h1, 5'h00};
			`ICTM_OP_MEMORY_COMPARE_POSTINC:
				row = {8'h01, 8'h00, 8'h08, 4'h2, 4'h1, 4'h0, 5'h00};
			// Single operand
			`ICTM_OP_CLEAR_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_CLEAR_MEM:
				row = {8'h00, 8'h02, 8'h04, 4'h0, 4'h1, 4'h1, 5'h18};
			`ICTM_OP_NEGATE_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_NEGATE_MEM:
				row = {8'h00, 8'h03, 8'h05, 4'h0, 4'h1, 4'h1, 5'h18};
			`ICTM_OP_SIGN_EXTEND_REG:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_DECIMAL_NEGATE_REG:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_DECIMAL_NEGATE_MEM:
				row = {8'h00, 8'h02, 8'h06, 4'h0, 4'h1, 4'h1, 5'h08};
			`ICTM_OP_SET_COND_REG:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_SET_COND_MEM:
				row = {8'h02, 8'h02, 8'h06, 4'h0, 4'h1, 4'h1, 5'h08};
			`ICTM_OP_TEST_AND_SET_REG:
				row = {8'h04, 8'h00, 8'h06, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_TEST_AND_SET_MEM:
				row = {8'h01, 8'h00, 8'h0a, 4'h0, 4'h1, 4'h1, 5'h08};
			`ICTM_OP_TEST_MEM:
				row = {8'h00, 8'h00, 8'h02, 4'h0, 4'h1, 4'h0, 5'h08};
			// Shift and rotate; fixed forms ignore the count
			`ICTM_OP_LOGICAL_SHIFT_REGCNT:
				row = {8'h00, 8'h00, 8'h00, 4'h0, 4'h1, 4'h0, 3'h0, `ICTM_SHF_REGCNT};
			`ICTM_OP_LOGICAL_SHIFT_IMM:
				row = {8'h04, 8'h00, 8'h06, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_LOGICAL_SHIFT_MEM:
				row = {8'h00, 8'h02, 8'h06, 4'h0, 4'h1, 4'h1, 5'h08};
			`ICTM_OP_ROTATE_THROUGH_EXTEND_REGCNT:
				row = {8'h00, 8'h00, 8'h00, 4'h0, 4'h1, 4'h0, 3'h0, `ICTM_SHF_ROTX_REG};
			`ICTM_OP_ROTATE_THROUGH_EXTEND_IMM:
				row = {8'h00, 8'h00, 8'h00, 4'h0, 4'h1, 4'h0, 3'h0, `ICTM_SHF_ROTX_IMM};
			// Bit manipulation; immediate bit numbers need an extra fetch
			`ICTM_OP_BIT_CHANGE_IMM_REG:
				row = {8'h02, 8'h00, 8'h06, 4'h0, 4'h2, 4'h0, 5'h04};
			`ICTM_OP_BIT_CHANGE_REG_REG:
				row = {8'h04, 8'h00, 8'h06, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_BIT_CHANGE_IMM_MEM:
				row = {8'h01, 8'h02, 8'h08, 4'h0, 4'h2, 4'h1, 5'h0c};
			`ICTM_OP_BIT_CHANGE_REG_MEM:
				row = {8'h02, 8'h02, 8'h08, 4'h0, 4'h1, 4'h1, 5'h08};
			`ICTM_OP_BIT_TEST_IMM_REG:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h2, 4'h0, 5'h04};
			`ICTM_OP_BIT_TEST_REG_REG:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_BIT_TEST_IMM_MEM:
				row = {8'h01, 8'h00, 8'h04, 4'h0, 4'h2, 4'h0, 5'h0c};
			`ICTM_OP_BIT_TEST_REG_MEM:
				row = {8'h02, 8'h00, 8'h08, 4'h0, 4'h1, 4'h0, 5'h08};
			// Conditional branches carry complete times
			`ICTM_OP_BRANCH_TAKEN:
				row = {8'h02, 8'hfe, 8'h08, 4'h0, 4'h2, 4'h0, 5'h00};
			`ICTM_OP_BRANCH_BYTE_NOT_TAKEN:
				row = {8'h02, 8'h00, 8'h04, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_BRANCH_WORD_NOT_TAKEN:
				row = {8'h00, 8'h00, 8'h04, 4'h0, 4'h2, 4'h0, 5'h00};
			`ICTM_OP_BRANCH_LONG_NOT_TAKEN:
				row = {8'h00, 8'h00, 8'h06, 4'h0, 4'h3, 4'h1, 5'h00};
			`ICTM_OP_DECREMENT_AND_BRANCH_TRUE:
				row = {8'h01, 8'h01, 8'h04, 4'h0, 4'h2, 4'h0, 5'h00};
			`ICTM_OP_DECREMENT_AND_BRANCH_EXPIRED:
				row = {8'h02, 8'h00, 8'h06, 4'h0, 4'h2, 4'h0, 5'h00};
			`ICTM_OP_DECREMENT_AND_BRANCH_TAKEN:
				row = {8'h06, 8'hfe, 8'h0a, 4'h0, 4'h2, 4'h0, 5'h00};
			// Loop mode: the loop body is already held, so fewer fetches
			`ICTM_OP_LOOP_DECREMENT_TRUE:
				row = {8'h04, 8'h00, 8'h06, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_LOOP_DECREMENT_EXPIRED:
				row = {8'h06, 8'h00, 8'h08, 4'h0, 4'h1, 4'h0, 5'h00};
			`ICTM_OP_LOOP_DECREMENT_TAKEN:
				row = {8'h06, 8'h00, 8'h0a, 4'h0, 4'h0, 4'h0, 5'h00};
			// Unknown class: answered as illegal, with no busy window
			default:
				known = 1'b0;
		endcase
	end

	// Derived figures for the presented instruction
	always @*
	begin
		next_head = row[`ICTM_ROW_HEAD];
		next_tail = row[`ICTM_ROW_TAIL];
		next_total = {2'h0, row[`ICTM_ROW_TOTAL]};
		next_reads = row[`ICTM_ROW_READS];
		next_writes = row[`ICTM_ROW_WRITES];
		// Tails are two's complement; the eight-bit cut keeps the sign
		long_tail = {2'h0, row[`ICTM_ROW_TAIL]} + `ICTM_LONG_EXTRA;
		// Count-dependent forms set head and base total both to the shift clocks
		if (row[`ICTM_ROW_SHF] != `ICTM_SHF_NONE)
		begin
			next_head = {1'h0, shift_clocks};
			next_total = {3'h0, shift_clocks};
		end
		// Long operands on a 16-bit bus take two bus cycles
		if (row[`ICTM_ROW_XLONG] && req_long)
		begin
			next_tail = long_tail[7:0];
			next_total = next_total + `ICTM_LONG_EXTRA;
			next_writes = next_writes + 4'h1;
		end
		if (row[`ICTM_ROW_ADD_EA])
			next_total = next_total + {2'h0, req_ea_clocks};
		if (row[`ICTM_ROW_ADD_IMM])
			next_total = next_total + {2'h0, req_imm_clocks};
		// Each access past two clocks stretches execution
		// Slow memory stretches reads, prefetches and writes alike
		accesses = next_reads + row[`ICTM_ROW_PREF] + next_writes;
		case (bus_wait_clocks)
			2'h1:
				wait_extra = {6'h00, accesses};
			2'h2:
				wait_extra = {5'h00, accesses, 1'b0};
			2'h3:
				wait_extra = {5'h00, accesses, 1'b0} + {6'h00, accesses};
			default:
				wait_extra = 10'h000;
		endcase
		next_total = next_total + wait_extra;
		// Tail of the previous instruction hides under this head
		// A negative tail or head hides nothing
		next_overlap = 8'h00;
		if (!prev_tail[7] && !next_head[7])
			next_overlap = (prev_tail < next_head) ? prev_tail : next_head;
	end

	// Handshake flags: one-cycle answer and its two qualifiers
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp_illegal <= 1'b0;
			rsp_nominal <= 1'b0;
		end
		else
		begin
			rsp_valid <= take;
			if (take)
			begin
				rsp_illegal <= !known;
				// Figures hold only for a 16-bit bus at two-clock accesses
				rsp_nominal <= known && bus_16bit && (bus_wait_clocks == 2'h0);
			end
		end
	end

	// Figures of the last known instruction; an unknown class leaves them standing
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rsp_head <= 8'h00;
			rsp_tail <= 8'h00;
			rsp_total <= 10'h000;
			rsp_reads <= 4'h0;
			rsp_prefetch <= 4'h0;
			rsp_writes <= 4'h0;
		end
		else if (take && known)
		begin
			rsp_head <= next_head;
			rsp_tail <= next_tail;
			rsp_total <= next_total;
			rsp_reads <= next_reads;
			rsp_prefetch <= row[`ICTM_ROW_PREF];
			rsp_writes <= next_writes;
		end
	end

	// Overlap with the previous tail and the running stream sum
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			overlap <= 8'h00;
			prev_tail <= 8'h00;
			stream_clocks <= {STREAM_W{1'b0}};
		end
		else if (take && known)
		begin
			overlap <= next_overlap;
			prev_tail <= next_tail;
			// Stream sum wraps at its width; no saturation
			stream_clocks <= stream_clocks + {{(STREAM_W-10){1'b0}}, next_total}
				- {{(STREAM_W-8){1'b0}}, next_overlap};
		end
	end

	// Busy window: exactly the total clocks after the take edge
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			remaining <= 10'h000;
		end
		else
		begin
			done <= 1'b0;
			if (take && known)
			begin
				busy <= 1'b1;
				remaining <= next_total;
			end
			else if (busy)
			begin
				remaining <= remaining - 10'h001;
				if (remaining == 10'h001)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// file: tb/ictm_timing_sva.sv
// Port assertions for the instruction cycle timing model
`timescale 1ns/1ps
`default_nettype none
`include "ictm_map.vh"
module ictm_timing_sva
#(
	parameter STREAM_W = 16
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Issue and bus configuration
	input wire req_valid,
	input wire [5:0] req_op,
	input wire req_long,
	input wire [7:0] req_ea_clocks,
	input wire bus_16bit,
	input wire [1:0] bus_wait_clocks,
	// Results
	input wire rsp_valid,
	input wire rsp_illegal,
	input wire rsp_nominal,
	input wire [7:0] rsp_head,
	input wire [7:0] rsp_tail,
	input wire [9:0] rsp_total,
	input wire [3:0] rsp_prefetch,
	input wire [3:0] rsp_writes,
	input wire busy,
	input wire done,
	input wire [7:0] overlap,
	input wire [STREAM_W-1:0] stream_clocks
);
	logic [9:0] busy_cnt;
	logic [STREAM_W-1:0] prev_stream;
	wire [STREAM_W-1:0] exp_stream;
	wire take;
	wire nom_in;
	assign exp_stream = prev_stream + rsp_total - overlap;
	assign take = req_valid && !busy;
	assign nom_in = bus_16bit && (bus_wait_clocks == 2'h0);
	// Busy length is counted from the response edge
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			busy_cnt <= 10'h000;
			prev_stream <= {STREAM_W{1'b0}};
		end
		else
		begin
			prev_stream <= stream_clocks;
			if (rsp_valid)
				busy_cnt <= 10'h001;
			else if (busy)
				busy_cnt <= busy_cnt + 10'h001;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_take_answer: assert property (take |=> rsp_valid)
		else $error("no response after a take");
	a_busy_total: assert property (done |-> busy_cnt == rsp_total)
		else $error("busy span differs from total");
	a_shift_head: assert property (take && nom_in &&
		(req_op == `ICTM_OP_LOGICAL_SHIFT_REGCNT ||
		req_op == `ICTM_OP_ROTATE_THROUGH_EXTEND_REGCNT) |=>
		rsp_head == rsp_total[7:0] && rsp_total >= 10'h006)
		else $error("register count shift head or floor wrong");
	a_nominal_flag: assert property (rsp_valid && !rsp_illegal |-> rsp_nominal == $past(nom_in))
		else $error("nominal flag wrong");
	a_long_extra: assert property (take && nom_in && req_long &&
		req_ea_clocks == 8'h00 && req_op == `ICTM_OP_QUICK_ADD_MEM |=>
		rsp_tail == 8'h05 && rsp_total == 10'h007 && rsp_writes == 4'h2)
		else $error("long operand extra clocks wrong");
	a_branch_back: assert property (take && nom_in && req_op == `ICTM_OP_BRANCH_TAKEN
		|=> rsp_head == 8'h02 && rsp_tail == 8'hfe && rsp_total == 10'h008 &&
		rsp_prefetch == 4'h2)
		else $error("taken branch figures wrong");
	a_stream_sum: assert property (rsp_valid && !rsp_illegal |-> stream_clocks == exp_stream)
		else $error("stream sum wrong");
	a_refuse_busy: assert property (busy |=> !rsp_valid)
		else $error("request taken while busy");
	c_illegal: cover property (rsp_valid && rsp_illegal);
	c_done: cover property (done);
	c_slow: cover property (rsp_valid && !rsp_nominal);
endmodule
bind ictm_timing ictm_timing_sva #(.STREAM_W(STREAM_W)) i_ictm_timing_sva (.clk_sys(clk_sys),
	.rst_n(rst_n), .req_valid(req_valid), .req_op(req_op), .req_long(req_long),
	.req_ea_clocks(req_ea_clocks), .bus_16bit(bus_16bit), .bus_wait_clocks(bus_wait_clocks),
	.rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal), .rsp_nominal(rsp_nominal),
	.rsp_head(rsp_head), .rsp_tail(rsp_tail), .rsp_total(rsp_total),
	.rsp_prefetch(rsp_prefetch), .rsp_writes(rsp_writes), .busy(busy), .done(done),
	.overlap(overlap), .stream_clocks(stream_clocks));
`default_nettype wire

// file: tb/ictm_mem_bus.sv
// External memory bus model: access speed and width seen by the core
`timescale 1ns/1ps
`default_nettype none
module ictm_mem_bus
(
	// Test control
	input wire logic narrow,
	input wire logic [1:0] slow,
	// Bus configuration
	output logic bus_16bit,
	output logic [1:0] bus_wait_clocks
);
	// Two-clock accesses unless the bench slows them
	assign bus_wait_clocks = slow;
	assign bus_16bit = !narrow;
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the instruction cycle timing model
`timescale 1ns/1ps
`default_nettype none
`include "ictm_map.vh"
module testbench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_long = 1'b0;
	logic narrow = 1'b0;
	logic [1:0] slow = 2'h0;
	logic [5:0] req_op = 6'h00;
	logic [5:0] req_count = 6'h00;
	logic [7:0] req_ea_clocks = 8'h00;
	logic [7:0] req_imm_clocks = 8'h00;
	logic [15:0] exp_stream = 16'h0000;
	logic [7:0] prev_tail = 8'h00;
	wire rsp_valid, rsp_illegal, rsp_nominal, busy, done, bus_16bit;
	wire [1:0] bus_wait_clocks;
	wire [7:0] rsp_head, rsp_tail, overlap;
	wire [9:0] rsp_total;
	wire [3:0] rsp_reads, rsp_prefetch, rsp_writes;
	wire [15:0] stream_clocks;
	integer error_cnt = 0;
	integer cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	ictm_mem_bus i_ictm_mem_bus (.narrow(narrow), .slow(slow), .bus_16bit(bus_16bit),
		.bus_wait_clocks(bus_wait_clocks));
	ictm_timing #(.STREAM_W(16)) i_ictm_timing (.clk_sys(clk_sys), .rst_n(rst_n),
		.req_valid(req_valid), .req_op(req_op), .req_long(req_long), .req_count(req_count),
		.req_ea_clocks(req_ea_clocks), .req_imm_clocks(req_imm_clocks), .bus_16bit(bus_16bit),
		.bus_wait_clocks(bus_wait_clocks), .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal),
		.rsp_nominal(rsp_nominal), .rsp_head(rsp_head), .rsp_tail(rsp_tail),
		.rsp_total(rsp_total), .rsp_reads(rsp_reads), .rsp_prefetch(rsp_prefetch),
		.rsp_writes(rsp_writes), .busy(busy), .done(done), .overlap(overlap),
		.stream_clocks(stream_clocks));
	task test_done;
	begin
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("FAIL %0t value %h expected %h", $time, got, exp);
		end
	end
	endtask
	task chk_bit(input got, input exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	function integer shf(input [1:0] m, input integer n);
		integer v;
		begin
			if (m == `ICTM_SHF_REGCNT)
				v = 3 + n / 4 + n % 4 + ((n / 4 + n % 4 + 1) % 2);
			else if (m == `ICTM_SHF_ROTX_REG)
				v = 3 + n + ((n + 1) % 2);
			else
				v = 2 + (n > 8 ? 8 : n) + ((n > 8 ? 8 : n) % 2);
			shf = (v < 6) ? 6 : v;
		end
	endfunction
	// Entered just after an edge with the block idle; returns in the cycle of done
	task issue(input [5:0] op, input lng, input [5:0] cnt, input [7:0] ea, input [7:0] imm,
		input [7:0] h, input [7:0] t, input [9:0] tot, input [3:0] r, input [3:0] p,
		input [3:0] w);
		integer k;
		logic [7:0] ov;
		begin
			req_op = op;
			req_long = lng;
			req_count = cnt;
			req_ea_clocks = ea;
			req_imm_clocks = imm;
			req_valid = 1'b1;
			@(posedge clk_sys);
			#1;
			req_valid = 1'b0;
			ov = (prev_tail[7] || h[7]) ? 8'h00 : ((prev_tail < h) ? prev_tail : h);
			exp_stream = exp_stream + tot - ov;
			prev_tail = t;
			chk_bit(rsp_valid, 1'b1);
			chk_bit(rsp_illegal, 1'b0);
			chk_bit(rsp_nominal, !narrow && slow == 2'h0);
			chk({8'h00, rsp_head}, {8'h00, h});
			chk({8'h00, rsp_tail}, {8'h00, t});
			chk({6'h00, rsp_total}, {6'h00, tot});
			chk({4'h0, rsp_reads, rsp_prefetch, rsp_writes}, {4'h0, r, p, w});
			chk({8'h00, overlap}, {8'h00, ov});
			chk(stream_clocks, exp_stream);
			k = 0;
			while (busy === 1'b1 && k < 300)
			begin
				@(posedge clk_sys);
				#1;
				k = k + 1;
			end
			chk(k[15:0], {6'h00, tot});
			chk_bit(done, 1'b1);
		end
	endtask
	task t_quick;
	begin
		issue(`ICTM_OP_QUICK_CONSTANT_LOAD, 0, 0, 0, 0, 0, 0, 2, 0, 1, 0);
		issue(`ICTM_OP_QUICK_ADD_MEM, 0, 0, 0, 0, 0, 3, 5, 0, 1, 1);
		issue(`ICTM_OP_QUICK_ADD_MEM, 1, 0, 0, 0, 0, 5, 7, 0, 1, 2);
		issue(`ICTM_OP_IMM_REG, 0, 0, 0, 4, 0, 0, 6, 0, 1, 0);
		issue(`ICTM_OP_IMM_MEM, 0, 0, 3, 4, 0, 3, 12, 0, 1, 1);
	end
	endtask
	task t_memory;
	begin
		issue(`ICTM_OP_DECIMAL_ADD_EXTEND_MEM, 0, 0, 5, 0, 2, 2, 12, 2, 1, 1);
		issue(`ICTM_OP_MEMORY_COMPARE_POSTINC, 0, 0, 5, 0, 1, 0, 8, 2, 1, 0);
		issue(`ICTM_OP_TEST_AND_SET_MEM, 0, 0, 0, 0, 1, 0, 10, 0, 1, 1);
	end
	endtask
	task t_branch;
	begin
		issue(`ICTM_OP_BRANCH_TAKEN, 0, 0, 0, 0, 2, 8'hfe, 8, 0, 2, 0);
		issue(`ICTM_OP_BRANCH_LONG_NOT_TAKEN, 0, 0, 0, 0, 0, 0, 6, 0, 3, 1);
		issue(`ICTM_OP_DECREMENT_AND_BRANCH_TAKEN, 0, 0, 0, 0, 6, 8'hfe, 10, 0, 2, 0);
	end
	endtask
	task t_shift;
		integer i;
		integer v;
		begin
			issue(`ICTM_OP_BIT_TEST_REG_REG, 0, 0, 0, 0, 2, 0, 4, 0, 1, 0);
			issue(`ICTM_OP_LOGICAL_SHIFT_IMM, 0, 1, 0, 0, 4, 0, 6, 0, 1, 0);
			issue(`ICTM_OP_LOGICAL_SHIFT_IMM, 0, 7, 0, 0, 4, 0, 6, 0, 1, 0);
			for (i = 0; i < 4; i = i + 1)
			begin
				v = shf(`ICTM_SHF_REGCNT, i * 21);
				issue(`ICTM_OP_LOGICAL_SHIFT_REGCNT, 0, i * 21, 0, 0, v, 0, v, 0, 1, 0);
				v = shf(`ICTM_SHF_ROTX_REG, i * 21);
				issue(`ICTM_OP_ROTATE_THROUGH_EXTEND_REGCNT, 0, i * 21, 0, 0, v, 0, v, 0, 1, 0);
				v = shf(`ICTM_SHF_ROTX_IMM, i * 3);
				issue(`ICTM_OP_ROTATE_THROUGH_EXTEND_IMM, 0, i * 3, 0, 0, v, 0, v, 0, 1, 0);
			end
		end
	endtask
	task t_bus;
	begin
		slow = 2'h1;
		issue(`ICTM_OP_QUICK_CONSTANT_LOAD, 0, 0, 0, 0, 0, 0, 3, 0, 1, 0);
		slow = 2'h2;
		issue(`ICTM_OP_DECIMAL_ADD_EXTEND_MEM, 0, 0, 0, 0, 2, 2, 20, 2, 1, 1);
		slow = 2'h3;
		issue(`ICTM_OP_QUICK_ADD_MEM, 1, 0, 0, 0, 0, 5, 16, 0, 1, 2);
		slow = 2'h0;
		narrow = 1'b1;
		issue(`ICTM_OP_QUICK_CONSTANT_LOAD, 0, 0, 0, 0, 0, 0, 2, 0, 1, 0);
		narrow = 1'b0;
	end
	endtask
	task t_illegal;
	begin
		req_op = 6'h3f;
		req_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		chk_bit(rsp_valid, 1'b1);
		chk_bit(rsp_illegal, 1'b1);
		chk_bit(rsp_nominal, 1'b0);
		chk_bit(busy, 1'b0);
		chk(stream_clocks, exp_stream);
		@(posedge clk_sys);
		#1;
	end
	endtask
	// Mid-run reset while idle: every output returns to zero
	task t_reset;
	begin
		rst_n = 1'b0;
		@(posedge clk_sys);
		#1;
		chk({rsp_valid, rsp_illegal, rsp_nominal, busy, done, 3'h0, overlap}, 16'h0000);
		chk({rsp_head, rsp_tail}, 16'h0000);
		chk({6'h00, rsp_total}, 16'h0000);
		chk({4'h0, rsp_reads, rsp_prefetch, rsp_writes}, 16'h0000);
		chk(stream_clocks, 16'h0000);
		rst_n = 1'b1;
		exp_stream = 16'h0000;
		prev_tail = 8'h00;
	end
	endtask
	initial
	begin
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		t_quick;
		t_memory;
		t_branch;
		t_illegal;
		t_reset;
		t_shift;
		t_bus;
		test_done;
	end
	initial
	begin
		#100000;
		error_cnt = error_cnt + 1;
		$display("FAIL %0t watchdog expired", $time);
		test_done;
	end
endmodule
`default_nettype wire
